// File: dv/aecm_cfg_host.sv
// Purpose: Configuration software model issuing dword accesses
// Assumes: Requests launched at the falling edge, one cycle each
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module aecm_cfg_host (
    // Clock
    input  wire logic        i_core_clk,
    // Request
    output logic             o_wr,
    output logic             o_rd,
    output logic      [11:0] o_addr,
    output logic      [31:0] o_wdata,
    output logic      [3:0]  o_be,
    // Answer
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 12'h000;
        o_wdata = 32'h0000_0000;
        o_be = 4'h0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge i_core_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        o_be = b;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge i_core_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = (i_rvalid === 1'b1) ? i_rdata : 32'hXXXX_XXXX;
    endtask : rd
endmodule : aecm_cfg_host

// File: dv/aecm_ctrl_asserts.sv
// Purpose: Port assertions for the mask and control register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Enable outputs may lag a write by one or two cycles
`timescale 1ns/1ps
module aecm_ctrl_asserts (
    // Clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    // Configuration access
    input wire logic        i_cfg_wr,
    input wire logic        i_cfg_rd,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [3:0]  i_cfg_be,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_rvalid,
    // Events and outputs
    input wire logic [31:0] i_corr_detect,
    input wire logic        o_corr_msg,
    input wire logic        o_corr_log,
    input wire logic        o_e2e_crc_check_enable,
    input wire logic        o_e2e_crc_gen_enable
);
    // ------------------------------------------------------------------
    // Decode and properties
    // ------------------------------------------------------------------
    wire logic ctl_wr = i_cfg_wr && (i_cfg_addr == 12'h118);
    wire logic chk_wr = ctl_wr && i_cfg_be[1];
    wire logic gen_wr = ctl_wr && i_cfg_be[0];
    wire logic [31:0] wr_bits = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                                 {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}} & 32'h0000_31C1;
    logic      [31:0] mask_shadow_r;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            mask_shadow_r <= 32'h0000_2000;
        end else if (i_cfg_wr && i_cfg_addr == 12'h114) begin
            mask_shadow_r <= (mask_shadow_r & ~wr_bits) | (i_cfg_wdata & wr_bits);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    rd_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid)
        else $error("read not answered next cycle");
    cap_bits_a: assert property (o_cfg_rvalid && $past(i_cfg_addr) == 12'h118 |->
        o_cfg_rdata[7] && o_cfg_rdata[5] && o_cfg_rdata[31:9] == 23'h0)
        else $error("bad control read");
    mask_rsvd_a: assert property (o_cfg_rvalid && $past(i_cfg_addr) == 12'h114 |->
        (o_cfg_rdata & ~32'h0000_31C1) == 32'h0) else $error("reserved mask bit set");
    chk_set_a: assert property (chk_wr && i_cfg_wdata[8] |-> ##[1:2] o_e2e_crc_check_enable)
        else $error("check enable not set");
    gen_set_a: assert property (gen_wr && i_cfg_wdata[6] |-> ##[1:2] o_e2e_crc_gen_enable)
        else $error("gen enable not set");
    chk_hold_a: assert property ($changed(o_e2e_crc_check_enable) |->
        $past(chk_wr) || $past(chk_wr, 2)) else $error("check enable moved alone");
    gen_hold_a: assert property ($changed(o_e2e_crc_gen_enable) |->
        $past(gen_wr) || $past(gen_wr, 2)) else $error("gen enable moved alone");
    msg_cause_a: assert property (o_corr_msg |-> $past(|i_corr_detect))
        else $error("message without detect");
    log_pair_a: assert property (o_corr_log == o_corr_msg)
        else $error("log and message differ");
    msg_mask_a: assert property (o_corr_msg ==
        $past(|(i_corr_detect & 32'h0000_31C1 & ~mask_shadow_r)))
        else $error("mask not honoured");
    rdata_idle_a: assert property (!o_cfg_rvalid |-> o_cfg_rdata == 32'h0)
        else $error("read data not zero when idle");
endmodule : aecm_ctrl_asserts

bind aecm_ctrl aecm_ctrl_asserts u_asserts (.i_core_clk, .i_reset_n, .i_cfg_wr, .i_cfg_rd,
    .i_cfg_addr, .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .o_cfg_rvalid, .i_corr_detect,
    .o_corr_msg, .o_corr_log, .o_e2e_crc_check_enable, .o_e2e_crc_gen_enable);

// File: dv/aer_correctable_mask_ctrl_tb_top.sv
// Purpose: Self-checking bench for the mask and control registers
// Assumes: Inputs change at the falling edge
// Notes:   Table rows write then read back one register
`timescale 1ns/1ps
module aer_correctable_mask_ctrl_tb_top;
    typedef struct { logic [11:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e; } aecm_row_s;
    logic clk, rst_n, wr, rd, rvalid, udet, msg, log_o, chk, gen;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, det, ustat, got;
    logic [3:0]  be;
    logic [4:0]  upos;
    logic [127:0] hdr;
    int miscompares, samples_checked;
    aecm_row_s rows [6] = '{'{12'h114, 32'hFFFF_FFFF, 4'hF, 32'h0000_31C1},
        '{12'h114, 32'h0, 4'hF, 32'h0}, '{12'h118, 32'hFFFF_FFFF, 4'hF, 32'h0000_01E0},
        '{12'h118, 32'h0, 4'hF, 32'h0000_00A0}, '{12'h114, 32'hFFFF_FFFF, 4'h1, 32'h0000_00C1},
        '{12'h200, 32'hFFFF_FFFF, 4'hF, 32'h0}};
    aecm_cfg_host u_host (.i_core_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .o_be(be), .i_rdata(rdata), .i_rvalid(rvalid));
    aecm_ctrl u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_be(be), .o_cfg_rdata(rdata),
        .o_cfg_rvalid(rvalid), .i_corr_detect(det), .i_corr_header(hdr), .i_uncorr_detect(udet),
        .i_uncorr_pos(upos), .i_uncorr_status(ustat), .o_corr_msg(msg), .o_corr_log(log_o),
        .o_e2e_crc_check_enable(chk), .o_e2e_crc_gen_enable(gen));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic pulse(input logic [31:0] c, input logic u);
        @(negedge clk);
        det = c;
        udet = u;
        @(negedge clk);
        det = 32'h0;
        udet = 1'b0;
    endtask : pulse
    task automatic rst_and_defaults();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        u_host.rd(12'h114, got); check(got, 32'h0000_2000);
        u_host.rd(12'h118, got); check(got, 32'h0000_00A0);
        check(32'({chk, gen}), 32'h0);
    endtask : rst_and_defaults
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        {det, udet, upos, ustat, hdr} = '0;
        rst_and_defaults();
        foreach (rows[i]) begin
            u_host.wr(rows[i].a, rows[i].d, rows[i].b);
            u_host.rd(rows[i].a, got); check(got, rows[i].e);
        end
        u_host.wr(12'h118, 32'h0000_0140, 4'hF);
        @(negedge clk);
        check(32'({chk, gen}), 32'h3);
        hdr = {4{32'hA5A5_0F0F}};
        pulse(32'h1, 1'b0); check(32'({msg, log_o}), 32'h0);
        hdr = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
        pulse(32'h1000, 1'b0); check(32'({msg, log_o}), 32'h3);
        u_host.rd(12'h11C, got); check(got, 32'h1111_1111);
        u_host.rd(12'h128, got); check(got, 32'h4444_4444);
        u_host.rd(12'h124, got); check(got, 32'h3333_3333);
        u_host.rd(12'h110, got); check(got, 32'h0000_1001);
        u_host.wr(12'h110, 32'h0, 4'hF);
        u_host.rd(12'h110, got); check(got, 32'h0000_1001);
        u_host.wr(12'h110, 32'h1, 4'hF);
        u_host.rd(12'h110, got); check(got, 32'h0000_1000);
        ustat = 32'h20; upos = 5'd5;
        pulse(32'h0, 1'b1);
        u_host.rd(12'h118, got); check(got, 32'h0000_01E5);
        upos = 5'd9;
        pulse(32'h0, 1'b1);
        u_host.rd(12'h118, got); check(got, 32'h0000_01E5);
        ustat = 32'h200;
        pulse(32'h0, 1'b1);
        u_host.rd(12'h118, got); check(got, 32'h0000_01E9);
        rst_and_defaults();
        pulse(32'h2000, 1'b0); check(32'({msg, log_o}), 32'h0);
        u_host.rd(12'h110, got); check(got, 32'h0000_2000);
        tally_and_finish();
    end
endmodule : aer_correctable_mask_ctrl_tb_top

// File: hw/aecm_corr_status.sv
// Purpose: Correctable error status bits, write-one-to-clear
// Assumes: Detect pulses are on the core clock
// Notes:   A detect in the cycle of a clear keeps the bit set
`timescale 1ns/1ps
module aecm_corr_status (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Events and clear
    input  wire logic [31:0] i_detect,
    input  wire logic [31:0] i_clear,
    // State
    output logic      [31:0] o_status
);

    logic [31:0] status_r;
    logic [31:0] status_nxt;

    // RQ11 set wins over clear
    assign status_nxt = ((status_r & ~i_clear) | i_detect) & aecm_pkg::CORR_WMASK;
    assign o_status   = status_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            status_r <= aecm_pkg::ZERO_WORD;
        end else begin
            status_r <= status_nxt;
        end
    end

endmodule : aecm_corr_status

// File: hw/aecm_ctrl.sv
// Purpose: Correctable error mask and error capability/control registers
// Assumes: Config port reads and writes one dword per cycle, byte enables per lane
// Notes:   Read data and report outputs are registered; read data one cycle after request, enables two cycles after a write
`timescale 1ns/1ps
module aecm_ctrl (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    // Configuration access
    input  wire logic         i_cfg_wr,
    input  wire logic         i_cfg_rd,
    input  wire logic [11:0]  i_cfg_addr,
    input  wire logic [31:0]  i_cfg_wdata,
    input  wire logic [3:0]   i_cfg_be,
    output logic      [31:0]  o_cfg_rdata,
    output logic              o_cfg_rvalid,
    // Correctable error detectors
    input  wire logic [31:0]  i_corr_detect,
    input  wire logic [127:0] i_corr_header,
    // Uncorrectable error events from the status block
    input  wire logic         i_uncorr_detect,
    input  wire logic [4:0]   i_uncorr_pos,
    input  wire logic [31:0]  i_uncorr_status,
    // Report outputs
    output logic              o_corr_msg,
    output logic              o_corr_log,
    output logic              o_e2e_crc_check_enable,
    output logic              o_e2e_crc_gen_enable
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [31:0] corr_mask_r;
    logic        check_en_r;
    logic        gen_en_r;
    logic [4:0]  first_err_r;
    logic        first_valid_r;
    logic [31:0] corr_status;
    logic [31:0] log_word;

    wire sel_status = (i_cfg_addr == aecm_pkg::OFF_CORR_STATUS);
    wire sel_mask   = (i_cfg_addr == aecm_pkg::OFF_CORR_MASK);
    wire sel_ctrl   = (i_cfg_addr == aecm_pkg::OFF_CAP_CONTROL);
    wire sel_log    = (i_cfg_addr >= aecm_pkg::OFF_HDR_LOG0) &&
                      (i_cfg_addr <= aecm_pkg::OFF_HDR_LOG3);

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    wire [31:0] wbits   = i_cfg_wdata & lane_mask(i_cfg_be);
    wire [31:0] clr_vec = (i_cfg_wr && sel_status) ? wbits : aecm_pkg::ZERO_WORD;
    wire [1:0]  log_idx = 2'((i_cfg_addr - aecm_pkg::OFF_HDR_LOG0) >> 2);

    // ------------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------------
    // RQ5 reserved bits stay zero
    wire [31:0] mask_nxt = (corr_mask_r & ~(aecm_pkg::CORR_WMASK & lane_mask(i_cfg_be)))
                         | (wbits & aecm_pkg::CORR_WMASK);

    // RQ2 RQ3 RQ4 writable masks
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            corr_mask_r <= aecm_pkg::CORR_MASK_RESET;
        end else if (i_cfg_wr && sel_mask) begin
            corr_mask_r <= mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Capability and control register
    // ------------------------------------------------------------------
    // RQ6 RQ8 enable bits
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            check_en_r <= 1'b0;
            gen_en_r   <= 1'b0;
        end else if (i_cfg_wr && sel_ctrl) begin
            if (i_cfg_be[1]) begin
                check_en_r <= i_cfg_wdata[aecm_pkg::BIT_CHECK_ENABLE];
            end
            if (i_cfg_be[0]) begin
                gen_en_r <= i_cfg_wdata[aecm_pkg::BIT_GEN_ENABLE];
            end
        end
    end

    // RQ10 RQ13 first error pointer
    wire first_cleared = first_valid_r && !i_uncorr_status[first_err_r];

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            first_err_r   <= 5'h00;
            first_valid_r <= 1'b0;
        end else if (i_uncorr_detect && (!first_valid_r || first_cleared)) begin
            first_err_r   <= i_uncorr_pos;
            first_valid_r <= 1'b1;
        end else if (first_cleared) begin
            first_valid_r <= 1'b0;
        end
    end

    // RQ7 RQ9 fixed capable bits, RQ5 upper bits zero
    wire [31:0] ctrl_word = {23'h000000, check_en_r, 1'b1, gen_en_r, 1'b1, first_err_r};

    // ------------------------------------------------------------------
    // Status and header log
    // ------------------------------------------------------------------
    aecm_corr_status u_status (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_detect   (i_corr_detect),
        .i_clear    (clr_vec),
        .o_status   (corr_status)
    );

    // RQ1 masked errors neither logged nor reported
    wire [31:0] reportable = i_corr_detect & aecm_pkg::CORR_WMASK & ~corr_mask_r;
    wire        report_any = |reportable;

    aecm_header_log #(
        .DWORDS (4)
    ) u_log (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_capture  (report_any),
        .i_header   (i_corr_header),
        .i_index    (log_idx),
        .o_word     (log_word)
    );

    // ------------------------------------------------------------------
    // Read mux and outputs
    // ------------------------------------------------------------------
    wire [31:0] rd_mux = sel_status ? corr_status :
                         sel_mask   ? corr_mask_r :
                         sel_ctrl   ? ctrl_word   :
                         sel_log    ? log_word    : aecm_pkg::ZERO_WORD;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_cfg_rdata            <= aecm_pkg::ZERO_WORD;
            o_cfg_rvalid           <= 1'b0;
            o_corr_msg             <= 1'b0;
            o_corr_log             <= 1'b0;
            o_e2e_crc_check_enable <= 1'b0;
            o_e2e_crc_gen_enable   <= 1'b0;
        end else begin
            o_cfg_rdata            <= i_cfg_rd ? rd_mux : aecm_pkg::ZERO_WORD;
            o_cfg_rvalid           <= i_cfg_rd;
            o_corr_msg             <= report_any;
            o_corr_log             <= report_any;
            o_e2e_crc_check_enable <= check_en_r;
            o_e2e_crc_gen_enable   <= gen_en_r;
        end
    end

endmodule : aecm_ctrl

// File: hw/aecm_header_log.sv
// Purpose: Four-dword header log of the packet behind the latest logged error
// Assumes: Header words arrive with the log strobe
// Notes:   Read only to software
`timescale 1ns/1ps
module aecm_header_log #(
    parameter int DWORDS = 4
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Capture
    input  wire logic        i_capture,
    input  wire logic [127:0] i_header,
    // Read
    input  wire logic [1:0]  i_index,
    output logic      [31:0] o_word
);

    logic [31:0] log_r [DWORDS];

    assign o_word = log_r[i_index];

    // RQ12 capture offending header
    always_ff @(posedge i_core_clk) begin
        for (int k = 0; k < DWORDS; k++) begin
            if (!i_reset_n) begin
                log_r[k] <= aecm_pkg::ZERO_WORD;
            end else if (i_capture) begin
                log_r[k] <= i_header[k*32 +: 32];
            end
        end
    end

endmodule : aecm_header_log

// File: hw/aecm_pkg.sv
// Purpose: Constants for the correctable error mask and error capability/control registers
// Assumes: Config access is a simple byte-addressed, dword-wide read/write port on the core clock
// Notes:   Offsets are byte addresses in the extended configuration space
//
// Summary of operation
// RQ1: Masked correctable error still sets status, but no log and no message.
// RQ2: Advisory nonfatal mask bit 13 resets to one.
// RQ3: Writable masks at bits 12, 8, 0; one masks.
// RQ4: Writable masks at bits 7 and 6; one masks.
// RQ5: Reserved bits read zero and ignore writes in both registers.
// RQ6: Control bit 8 enables end-to-end CRC checking.
// RQ7: Control bit 7 reads one: checking capable.
// RQ8: Control bit 6 enables end-to-end CRC generation.
// RQ9: Control bit 5 reads one: generation capable.
// RQ10: Bits 4:0 hold position of first uncorrectable error detected.
// RQ11: Correctable status bits clear only on a written one.
// RQ12: Logging captures offending packet header, up to four dwords.
// RQ13: First-error pointer holds until its uncorrectable status bit clears.
package aecm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CORR_STATUS  = 12'h110;
    localparam logic [11:0] OFF_CORR_MASK    = 12'h114;
    localparam logic [11:0] OFF_CAP_CONTROL  = 12'h118;
    localparam logic [11:0] OFF_HDR_LOG0     = 12'h11C;
    localparam logic [11:0] OFF_HDR_LOG1     = 12'h120;
    localparam logic [11:0] OFF_HDR_LOG2     = 12'h124;
    localparam logic [11:0] OFF_HDR_LOG3     = 12'h128;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_RX_ERROR      = 0;
    localparam int BIT_BAD_TLP       = 6;
    localparam int BIT_BAD_DLLP      = 7;
    localparam int BIT_REPLAY_ROLL   = 8;
    localparam int BIT_REPLAY_TMOUT  = 12;
    localparam int BIT_ADVISORY_NF   = 13;
    localparam int BIT_CHECK_ENABLE  = 8;
    localparam int BIT_CHECK_CAPABLE = 7;
    localparam int BIT_GEN_ENABLE    = 6;
    localparam int BIT_GEN_CAPABLE   = 5;
    localparam int FIRST_ERR_W       = 5;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] CORR_WMASK       = 32'h0000_31C1;
    localparam logic [31:0] CORR_MASK_RESET  = 32'h0000_2000;
    localparam logic [31:0] CAP_CTRL_RESET   = 32'h0000_00A0;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

endpackage : aecm_pkg
